// File: verilog/brad_defs.svh
// Purpose: Constants for the boot remap address decoder
// Assumes: Byte addresses on a 32-bit system bus
// Notes:   Definitions only
`ifndef BRAD_DEFS_SVH
`define BRAD_DEFS_SVH

// ****************************************
// Memory map
// ****************************************
`define BRAD_ADDR_W            32
`define BRAD_AREA_BITS         20
`define BRAD_AREA_BOOT         12'h000
`define BRAD_AREA_FLASH        12'h001
`define BRAD_AREA_SRAM         12'h002
`define BRAD_AREA_ROM          12'h003
`define BRAD_PERIPH_TOP        4'hf
`define BRAD_PERIPH_BITS       28
`define BRAD_OFFSET_W          28

// ****************************************
// Memory sizes in kilobytes
// ****************************************
`define BRAD_SRAM_KB_DEF       128
`define BRAD_FLASH_BANK_KB_DEF 256
`define BRAD_FLASH_BANKS_DEF   2
`define BRAD_ROM_KB_DEF        16
`define BRAD_KB_BYTES          1024

// ****************************************
// Boot select bits
// ****************************************
`define BRAD_NVM_BITS          3
`define BRAD_NVM_IDX_W         2
`define BRAD_NVM_BOOT_BIT      2
`define BRAD_NVM_RESET         3'h0

// ****************************************
// Timing
// ****************************************
`define BRAD_CLK_KHZ           100000
`define BRAD_ERASE_DEB_MS      200
`define BRAD_ERASE_DEB_CYCLES  (`BRAD_ERASE_DEB_MS * `BRAD_CLK_KHZ)
`define BRAD_DEB_CNT_W         25

`endif

// File: verilog/brad_pkg.sv
// Purpose: Types for the boot remap address decoder
// Assumes: Constants live in brad_defs.svh
// Notes:   Types only
package brad_pkg;

	typedef enum logic [2:0] {
		BRAD_RGN_NONE,
		BRAD_RGN_SRAM,
		BRAD_RGN_FLASH,
		BRAD_RGN_ROM,
		BRAD_RGN_PERIPH
	} brad_region_t;

endpackage

// File: verilog/brad_nvm_if.sv
// Purpose: Boot select state carried from the bit store to the decoder
// Assumes: One clock domain
// Notes:   Internal carrier only
`timescale 1ns/1ps
`default_nettype none
`include "brad_defs.svh"

interface brad_nvm_if;
	logic [`BRAD_NVM_BITS-1:0] nvm_bits;
	logic                      boot_flash;
	logic                      erase_active;

	modport ctl (
		output nvm_bits,
		output boot_flash,
		output erase_active
	);
	modport dec (
		input nvm_bits,
		input boot_flash,
		input erase_active
	);
endinterface

`default_nettype wire

// File: verilog/brad_nvm_ctl.sv
// Purpose: Boot select bit store, its set and clear commands and erase debounce
// Assumes: Erase pin already synchronous to i_clk
// Notes:   Bits survive system reset; only power-on reset restores them
`timescale 1ns/1ps
`default_nettype none
`include "brad_defs.svh"

module brad_nvm_ctl #(
	parameter int DEBOUNCE_CYCLES = `BRAD_ERASE_DEB_CYCLES
) (
	input  wire logic                       i_clk,
	input  wire logic                       i_reset,
	input  wire logic                       i_por_reset,
	input  wire logic                       i_nvm_set_cmd,
	input  wire logic                       i_nvm_clear_cmd,
	input  wire logic [`BRAD_NVM_IDX_W-1:0] i_nvm_bit_num,
	input  wire logic                       i_erase,
	brad_nvm_if.ctl                         nvm
);

	localparam logic [`BRAD_DEB_CNT_W-1:0] DEB_LAST =
		`BRAD_DEB_CNT_W'(DEBOUNCE_CYCLES - 1);
	localparam logic [`BRAD_NVM_BITS-1:0] NVM_RESET = `BRAD_NVM_RESET;

	logic [`BRAD_DEB_CNT_W-1:0] deb_cnt_reg;
	logic                       erase_reg;
	logic [`BRAD_NVM_BITS-1:0]  bits_reg;

	// ****************************************
	// Erase debounce
	// ****************************************
	// Counts from the system clock; a glitch shorter than the window restarts it
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_erase) begin
			deb_cnt_reg <= '0;
		end else if (deb_cnt_reg != DEB_LAST) begin
			deb_cnt_reg <= deb_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			erase_reg <= 1'b0;
		end else begin
			erase_reg <= i_erase && (deb_cnt_reg == DEB_LAST);
		end
	end

	// ****************************************
	// Boot select bits
	// ****************************************
	// Erase beats a set command so a stuck boot image can always be escaped
	for (genvar gi = 0; gi < `BRAD_NVM_BITS; gi++) begin : g_bit
		always_ff @(posedge i_clk) begin
			if (i_por_reset) begin
				bits_reg[gi] <= NVM_RESET[gi];
			end else if (gi == `BRAD_NVM_BOOT_BIT && erase_reg) begin
				bits_reg[gi] <= 1'b0;
			end else if (i_nvm_set_cmd && i_nvm_bit_num == `BRAD_NVM_IDX_W'(gi)) begin
				bits_reg[gi] <= 1'b1;
			end else if (i_nvm_clear_cmd && i_nvm_bit_num == `BRAD_NVM_IDX_W'(gi)) begin
				bits_reg[gi] <= 1'b0;
			end
		end
	end

	assign nvm.nvm_bits     = bits_reg;
	assign nvm.boot_flash   = bits_reg[`BRAD_NVM_BOOT_BIT];
	assign nvm.erase_active = erase_reg;

endmodule

`default_nettype wire

// File: verilog/brad_decoder.sv
// Purpose: Routes each bus access to SRAM, Flash, ROM or the peripheral area, or flags it unmapped
// Assumes: Requests synchronous to i_clk; one-cycle registered answer
// Notes:   Address zero aliases ROM, Flash or SRAM by boot bit and remap state
`timescale 1ns/1ps
`default_nettype none
`include "brad_defs.svh"

// Operation
// - Before remap, SRAM answers only at its fixed base address.
// - After remap, SRAM also appears at address zero.
// - ROM always sits at its fixed base address.
// - Flash always sits at its fixed base address.
// - Before remap, boot bit 2 set aliases Flash at address zero.
// - Before remap, boot bit 2 clear aliases ROM at address zero.
// - Set and clear commands change the chosen boot select bit.
// - A debounced erase clears boot select bit 2.
// - SRAM size is a variant parameter: 128, 64 or 32 kilobytes.
// - Flash is two 256 KB banks or one 256 or 128 KB bank.
// - Selects for three 1 MB memory areas and one 256 MB peripheral area.
// - Remap puts SRAM where nonvolatile memory was aliased, for vectors.
// - Erase input must stay high 200 ms before acting.
module brad_decoder #(
	parameter int SRAM_KB         = `BRAD_SRAM_KB_DEF,
	parameter int FLASH_BANK_KB   = `BRAD_FLASH_BANK_KB_DEF,
	parameter int FLASH_BANKS     = `BRAD_FLASH_BANKS_DEF,
	parameter int ROM_KB          = `BRAD_ROM_KB_DEF,
	parameter int DEBOUNCE_CYCLES = `BRAD_ERASE_DEB_CYCLES
) (
	input  wire logic                       i_clk,
	input  wire logic                       i_reset,
	input  wire logic                       i_por_reset,
	input  wire logic                       i_valid,
	input  wire logic [`BRAD_ADDR_W-1:0]    i_addr,
	input  wire logic                       i_remap_cmd,
	input  wire logic                       i_nvm_set_cmd,
	input  wire logic                       i_nvm_clear_cmd,
	input  wire logic [`BRAD_NVM_IDX_W-1:0] i_nvm_bit_num,
	input  wire logic                       i_erase,
	output logic                            o_valid,
	output logic                            o_sram_sel,
	output logic                            o_flash_sel,
	output logic                            o_rom_sel,
	output logic                            o_periph_sel,
	output logic                            o_unmapped,
	output logic                            o_flash_bank,
	output logic [`BRAD_OFFSET_W-1:0]       o_offset,
	output logic                            o_remapped,
	output logic                            o_boot_flash,
	output logic [`BRAD_NVM_BITS-1:0]       o_nvm_bits,
	output logic                            o_erase_active
);

	// ****************************************
	// Helpers
	// ****************************************
	// Offset mask of a region; smaller memories mirror through their 1 MB area
	function automatic logic [`BRAD_AREA_BITS-1:0] brad_mask(input int kb);
		brad_mask = `BRAD_AREA_BITS'(kb * `BRAD_KB_BYTES - 1);
	endfunction

	function automatic brad_pkg::brad_region_t brad_area_region(
		input logic [`BRAD_ADDR_W-1:0] addr,
		input logic                    remapped,
		input logic                    boot_flash
	);
		logic [11:0] area;
		area = addr[`BRAD_ADDR_W-1:`BRAD_AREA_BITS];
		if (addr[`BRAD_ADDR_W-1 -: 4] == `BRAD_PERIPH_TOP) begin
			brad_area_region = brad_pkg::BRAD_RGN_PERIPH;
		end else begin
			case (area)
				`BRAD_AREA_BOOT: begin
					if (remapped) begin
						brad_area_region = brad_pkg::BRAD_RGN_SRAM;
					end else if (boot_flash) begin
						brad_area_region = brad_pkg::BRAD_RGN_FLASH;
					end else begin
						brad_area_region = brad_pkg::BRAD_RGN_ROM;
					end
				end
				`BRAD_AREA_FLASH: brad_area_region = brad_pkg::BRAD_RGN_FLASH;
				`BRAD_AREA_SRAM:  brad_area_region = brad_pkg::BRAD_RGN_SRAM;
				`BRAD_AREA_ROM:   brad_area_region = brad_pkg::BRAD_RGN_ROM;
				default:          brad_area_region = brad_pkg::BRAD_RGN_NONE;
			endcase
		end
	endfunction

	localparam logic [`BRAD_AREA_BITS-1:0] SRAM_MASK = brad_mask(SRAM_KB);
	localparam logic [`BRAD_AREA_BITS-1:0] ROM_MASK  = brad_mask(ROM_KB);
	localparam logic [`BRAD_AREA_BITS-1:0] BANK_MASK = brad_mask(FLASH_BANK_KB);
	localparam logic [`BRAD_AREA_BITS-1:0] FLASH_MASK =
		(FLASH_BANKS > 1) ? brad_mask(2 * FLASH_BANK_KB) : BANK_MASK;

	// ****************************************
	// Boot select store
	// ****************************************
	brad_nvm_if nvm ();

	brad_nvm_ctl #(
		.DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
	) u_nvm (
		.i_clk           (i_clk),
		.i_reset         (i_reset),
		.i_por_reset     (i_por_reset),
		.i_nvm_set_cmd   (i_nvm_set_cmd),
		.i_nvm_clear_cmd (i_nvm_clear_cmd),
		.i_nvm_bit_num   (i_nvm_bit_num),
		.i_erase         (i_erase),
		.nvm             (nvm.ctl)
	);

	// ****************************************
	// Remap state
	// ****************************************
	logic remap_reg;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			remap_reg <= 1'b0;
		end else if (i_remap_cmd) begin
			remap_reg <= 1'b1;
		end
	end

	// ****************************************
	// Decode
	// ****************************************
	brad_pkg::brad_region_t        region;
	logic [`BRAD_AREA_BITS-1:0]    area_off;
	logic [`BRAD_OFFSET_W-1:0]     offset_next;
	logic                          bank_next;

	assign region   = brad_area_region(i_addr, remap_reg, nvm.boot_flash);
	assign area_off = i_addr[`BRAD_AREA_BITS-1:0];

	always_comb begin
		offset_next = '0;
		bank_next   = 1'b0;
		case (region)
			brad_pkg::BRAD_RGN_SRAM: begin
				offset_next = `BRAD_OFFSET_W'(area_off & SRAM_MASK);
			end
			brad_pkg::BRAD_RGN_FLASH: begin
				offset_next = `BRAD_OFFSET_W'(area_off & BANK_MASK);
				// Upper half of the dual plane window falls in the second bank
				bank_next   = (FLASH_BANKS > 1) && ((area_off & FLASH_MASK) > BANK_MASK);
			end
			brad_pkg::BRAD_RGN_ROM: begin
				offset_next = `BRAD_OFFSET_W'(area_off & ROM_MASK);
			end
			brad_pkg::BRAD_RGN_PERIPH: begin
				offset_next = i_addr[`BRAD_PERIPH_BITS-1:0];
			end
			default: begin
				offset_next = '0;
			end
		endcase
	end

	// ****************************************
	// Registered answer
	// ****************************************
	// Access in the remap cycle still sees the old map; new map from the next one
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_valid      <= 1'b0;
			o_sram_sel   <= 1'b0;
			o_flash_sel  <= 1'b0;
			o_rom_sel    <= 1'b0;
			o_periph_sel <= 1'b0;
			o_unmapped   <= 1'b0;
		end else begin
			o_valid      <= i_valid;
			o_sram_sel   <= i_valid && region == brad_pkg::BRAD_RGN_SRAM;
			o_flash_sel  <= i_valid && region == brad_pkg::BRAD_RGN_FLASH;
			o_rom_sel    <= i_valid && region == brad_pkg::BRAD_RGN_ROM;
			o_periph_sel <= i_valid && region == brad_pkg::BRAD_RGN_PERIPH;
			o_unmapped   <= i_valid && region == brad_pkg::BRAD_RGN_NONE;
		end
	end

	// ****************************************
	// Offset and bank
	// ****************************************
	// Zeroed when idle so a stale address never reaches a memory
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_flash_bank <= 1'b0;
			o_offset     <= '0;
		end else begin
			o_flash_bank <= i_valid && bank_next;
			o_offset     <= i_valid ? offset_next : '0;
		end
	end

	// ****************************************
	// Status
	// ****************************************
	// Copy lags the live flag by one cycle
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_remapped <= 1'b0;
		end else begin
			o_remapped <= remap_reg;
		end
	end

	// Boot bits survive system reset, so the copy reloads right after it
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_boot_flash   <= 1'b0;
			o_nvm_bits     <= '0;
			o_erase_active <= 1'b0;
		end else begin
			o_boot_flash   <= nvm.boot_flash;
			o_nvm_bits     <= nvm.nvm_bits;
			o_erase_active <= nvm.erase_active;
		end
	end

endmodule

`default_nettype wire

// File: sim/brad_asserts.sv
// Purpose: Port-level checks of the boot remap decoder
// Assumes: Bound to brad_decoder; one clock domain
// Notes:   Quiet flag hides the one-cycle lag of the status copies
`timescale 1ns/1ps
`default_nettype none
`include "brad_defs.svh"
module brad_asserts (
	input wire logic                       i_clk,
	input wire logic                       i_reset,
	input wire logic                       i_por_reset,
	input wire logic                       i_valid,
	input wire logic [`BRAD_ADDR_W-1:0]    i_addr,
	input wire logic                       i_remap_cmd,
	input wire logic                       i_nvm_set_cmd,
	input wire logic                       i_nvm_clear_cmd,
	input wire logic [`BRAD_NVM_IDX_W-1:0] i_nvm_bit_num,
	input wire logic                       i_erase,
	input wire logic                       o_sram_sel,
	input wire logic                       o_flash_sel,
	input wire logic                       o_rom_sel,
	input wire logic                       o_periph_sel,
	input wire logic                       o_remapped,
	input wire logic                       o_boot_flash,
	input wire logic [`BRAD_NVM_BITS-1:0]  o_nvm_bits,
	input wire logic                       o_erase_active
);
	logic calm_reg;
	logic calm2_reg;
	// Status copies are only trusted after two cycles without commands
	always_ff @(posedge i_clk) begin
		calm_reg  <= !(i_reset | i_por_reset | i_remap_cmd | i_nvm_set_cmd | i_nvm_clear_cmd | i_erase);
		calm2_reg <= calm_reg;
	end
	wire logic zero = i_valid && i_addr[31:20] == 12'h000 && calm_reg && calm2_reg;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset || i_por_reset);
	a_sram_base: assert property (i_valid && i_addr[31:20] == 12'h002 |=> o_sram_sel)
		else $error("sram base not selected");
	a_flash_base: assert property (i_valid && i_addr[31:20] == 12'h001 |=> o_flash_sel)
		else $error("flash base not selected");
	a_rom_base: assert property (i_valid && i_addr[31:20] == 12'h003 |=> o_rom_sel)
		else $error("rom base not selected");
	a_periph_area: assert property (i_valid && i_addr[31:28] == 4'hf |=> o_periph_sel)
		else $error("peripheral area not selected");
	a_alias_remap: assert property (zero && o_remapped |=> o_sram_sel)
		else $error("zero alias not sram after remap");
	a_alias_flash: assert property (zero && !o_remapped && o_boot_flash |=> o_flash_sel)
		else $error("zero alias not flash");
	a_alias_rom: assert property (zero && !o_remapped && !o_boot_flash |=> o_rom_sel)
		else $error("zero alias not rom");
	a_remap_sticky: assert property (o_remapped && !i_reset |=> o_remapped)
		else $error("remap flag dropped");
	a_erase_clear: assert property (o_erase_active [*3] |-> !o_boot_flash)
		else $error("boot bit set during erase");
	a_set_cmd: assert property (i_nvm_set_cmd && i_nvm_bit_num == 2'h2 && !i_erase
		&& !$past(i_erase) |=> ##1 o_nvm_bits[2])
		else $error("set command lost");
	cover property (zero && o_boot_flash);
	cover property (zero && o_remapped);
	cover property (o_erase_active);
endmodule
`default_nettype wire

// File: sim/brad_master.sv
// Purpose: Bus master model issuing single accesses
// Assumes: One request per call
// Notes:   Released address shows the inverse of the last one
`timescale 1ns/1ps
`default_nettype none
module brad_master (
	input  wire logic        i_clk,
	output logic             o_valid,
	output logic [31:0]      o_addr
);
	initial begin
		o_valid = 1'b0;
		o_addr  = 32'h0000_0000;
	end
	task automatic put(input logic [31:0] a);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_addr  <= a;
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_addr  <= ~a;
	endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: Self-checking bench of the boot remap decoder
// Assumes: Debounce shortened to 8 cycles, 64 KB SRAM variant
// Notes:   Some zero-alias accesses follow a quiet gap so the alias checks engage
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk   = 1'b0;
	logic        rst   = 1'b1;
	logic        por   = 1'b1;
	logic        remap = 1'b0;
	logic        set   = 1'b0;
	logic        clr   = 1'b0;
	logic [1:0]  num   = 2'h0;
	logic        erase = 1'b0;
	logic        v;
	logic [31:0] a;
	logic        ov, s_sram, s_flash, s_rom, s_per, s_unm, bank, rmp, bflash, eact;
	logic [27:0] off;
	logic [2:0]  bits;
	int          err_total = 0;
	int          n_tests   = 0;
	always #5 clk = ~clk;
	brad_master m (.i_clk(clk), .o_valid(v), .o_addr(a));
	brad_decoder #(.SRAM_KB(64), .DEBOUNCE_CYCLES(8)) DUT (.i_clk(clk), .i_reset(rst),
		.i_por_reset(por), .i_valid(v), .i_addr(a), .i_remap_cmd(remap), .i_nvm_set_cmd(set),
		.i_nvm_clear_cmd(clr), .i_nvm_bit_num(num), .i_erase(erase), .o_valid(ov),
		.o_sram_sel(s_sram), .o_flash_sel(s_flash), .o_rom_sel(s_rom), .o_periph_sel(s_per),
		.o_unmapped(s_unm), .o_flash_bank(bank), .o_offset(off), .o_remapped(rmp),
		.o_boot_flash(bflash), .o_nvm_bits(bits), .o_erase_active(eact));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Selects in order sram, flash, rom, peripheral, unmapped
	task automatic acc(input logic [31:0] ad, input logic [4:0] sel, input logic [27:0] ex);
		m.put(ad);
		#1;
		chk("sel", {26'h0, ov, s_sram, s_flash, s_rom, s_per, s_unm}, {26'h0, 1'b1, sel});
		if (ex !== 28'hfff_ffff)
			chk("offset", {4'h0, off}, {4'h0, ex});
	endtask
	task automatic cmd(input logic r, input logic s, input logic c, input logic [1:0] n);
		@(posedge clk);
		remap <= r;
		set   <= s;
		clr   <= c;
		num   <= n;
		@(posedge clk);
		remap <= 1'b0;
		set   <= 1'b0;
		clr   <= 1'b0;
	endtask
	task automatic t_map();
		acc(32'h0000_0104, 5'b00100, 28'h000_0104);
		acc(32'h000f_fffc, 5'b00100, 28'h000_3ffc);
		acc(32'h0010_0010, 5'b01000, 28'h000_0010);
		chk("bank", {31'h0, bank}, 32'h0000_0000);
		acc(32'h0014_0010, 5'b01000, 28'h000_0010);
		chk("bank", {31'h0, bank}, 32'h0000_0001);
		acc(32'h0020_0010, 5'b10000, 28'h000_0010);
		acc(32'h0021_0004, 5'b10000, 28'h000_0004);
		acc(32'h0030_0008, 5'b00100, 28'h000_0008);
		acc(32'hf000_0020, 5'b00010, 28'h000_0020);
		acc(32'h1000_0000, 5'b00001, 28'h000_0000);
		$display("test map done");
	endtask
	task automatic t_boot();
		cmd(1'b0, 1'b1, 1'b0, 2'h2);
		acc(32'h0000_0040, 5'b01000, 28'h000_0040);
		chk("boot", {31'h0, bflash}, 32'h0000_0001);
		acc(32'h0000_0080, 5'b01000, 28'h000_0080);
		cmd(1'b0, 1'b1, 1'b0, 2'h0);
		cmd(1'b0, 1'b0, 1'b1, 2'h3);
		acc(32'h0000_0040, 5'b01000, 28'h000_0040);
		chk("bits", {29'h0, bits}, 32'h0000_0005);
		cmd(1'b0, 1'b0, 1'b1, 2'h2);
		acc(32'h0000_0040, 5'b00100, 28'h000_0040);
		chk("bits", {29'h0, bits}, 32'h0000_0001);
		$display("test boot done");
	endtask
	task automatic t_erase();
		cmd(1'b0, 1'b1, 1'b0, 2'h2);
		@(posedge clk) erase <= 1'b1;
		repeat (4) @(posedge clk);
		erase <= 1'b0;
		acc(32'h0000_0000, 5'b01000, 28'h000_0000);
		@(posedge clk) erase <= 1'b1;
		repeat (12) @(posedge clk);
		#1;
		chk("erase", {31'h0, eact}, 32'h0000_0001);
		chk("boot", {31'h0, bflash}, 32'h0000_0000);
		cmd(1'b0, 1'b1, 1'b0, 2'h2);
		@(posedge clk) erase <= 1'b0;
		acc(32'h0000_0000, 5'b00100, 28'h000_0000);
		$display("test erase done");
	endtask
	task automatic t_remap();
		cmd(1'b0, 1'b1, 1'b0, 2'h2);
		cmd(1'b1, 1'b0, 1'b0, 2'h0);
		acc(32'h0000_0010, 5'b10000, 28'h000_0010);
		acc(32'h0020_0010, 5'b10000, 28'h000_0010);
		chk("remap", {31'h0, rmp}, 32'h0000_0001);
		acc(32'h0001_fff0, 5'b10000, 28'h000_fff0);
		cmd(1'b0, 1'b0, 1'b1, 2'h2);
		acc(32'h0000_0010, 5'b10000, 28'h000_0010);
		cmd(1'b0, 1'b1, 1'b0, 2'h2);
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		acc(32'h0000_0010, 5'b01000, 28'h000_0010);
		chk("remap", {31'h0, rmp}, 32'h0000_0000);
		$display("test remap done");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		t_map();
		t_boot();
		t_erase();
		t_remap();
		final_report();
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		final_report();
	end
endmodule
bind brad_decoder brad_asserts u_chk (.i_clk(i_clk), .i_reset(i_reset),
	.i_por_reset(i_por_reset), .i_valid(i_valid), .i_addr(i_addr), .i_remap_cmd(i_remap_cmd),
	.i_nvm_set_cmd(i_nvm_set_cmd), .i_nvm_clear_cmd(i_nvm_clear_cmd),
	.i_nvm_bit_num(i_nvm_bit_num), .i_erase(i_erase), .o_sram_sel(o_sram_sel),
	.o_flash_sel(o_flash_sel), .o_rom_sel(o_rom_sel), .o_periph_sel(o_periph_sel),
	.o_remapped(o_remapped), .o_boot_flash(o_boot_flash), .o_nvm_bits(o_nvm_bits),
	.o_erase_active(o_erase_active));
`default_nettype wire
